/* hdl/adcctl_pkg.sv */
package adcctl_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CSR = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h04;
   localparam logic [7:0] ADDR_DAC_A = 8'h08;
   localparam logic [7:0] ADDR_DAC_B = 8'h0C;
   localparam logic [7:0] ADDR_VECTOR = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;
   // control/status word fields
   localparam int CSR_START = 0;
   localparam int CSR_GAIN_LO = 2;
   localparam int CSR_TRIG_EN = 4;
   localparam int CSR_RTC_EN = 5;
   localparam int CSR_DONE_IE = 6;
   localparam int CSR_DONE = 7;
   localparam int CSR_MUX_LO = 8;
   localparam int CSR_ERR_IE = 14;
   localparam int CSR_ERR = 15;
   // vector layout
   localparam int VEC_LO = 3;
   localparam logic [8:0] VEC_ERR_OFFSET = 9'h004;
   // interrupt status bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   // reset values
   localparam logic [15:0] CSR_RST = 16'h0000;
   localparam logic [11:0] DAC_RST = 12'h000;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int SETTLE_NS = 2000;
   localparam int CONV_NS = 10000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
   // notations and sequencer states
   typedef enum logic [1:0] {
      ADCCTL_BIN = 2'b00,
      ADCCTL_OFFS = 2'b01,
      ADCCTL_TWOS = 2'b10
   } adcctl_notation_t;
   typedef enum logic [1:0] {
      ADCCTL_IDLE = 2'b00,
      ADCCTL_SETTLE = 2'b01,
      ADCCTL_CONV = 2'b11
   } adcctl_state_t;
endpackage

/* hdl/adcctl_code_fmt.sv */
`timescale 1ns/10ps
module adcctl_code_fmt (
   // raw offset-binary sample and notation
   input wire logic [11:0] i_raw,
   input wire adcctl_pkg::adcctl_notation_t i_notation,
   // formatted result
   output logic [15:0] o_code
);
   import adcctl_pkg::*;
   always_comb begin
      case (i_notation)
         ADCCTL_TWOS: o_code = {{4{~i_raw[11]}}, ~i_raw[11], i_raw[10:0]};
         ADCCTL_BIN: o_code = {4'h0, i_raw};
         default: o_code = {4'h0, i_raw};
      endcase
   end
endmodule

/* hdl/adcctl_top.sv */
// What this block does
// - interrupt on done or error if enabled
// - done interrupt uses base vector
// - error vector is base plus four
// - base vector only bits 3 to 8
// - six jumpers set vector bits, in=one
// - gain 1/2/4/8 divides input range
// - 16 single-ended or 8 differential channels
// - straight binary: 7777 full, 0 at zero
// - twos complement sign-extended, offset default
// - start by program, clock, or trigger
// - trigger from backplane or connector, jumpered
// - clock and trigger start only when enabled
// - each DAC configured separately, legal pairs
// - trigger enable bit 4, clock bit 5
// - done bit 7, cleared by data read
// - error bit 15 on illegal start
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/10ps
module adcctl_top #(
   parameter int SETTLE_CYCLES = adcctl_pkg::SETTLE_CYC,
   parameter int CONV_CYCLES = adcctl_pkg::CONV_CYC
) (
   // clock, reset, enable
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // bus initialize
   input wire logic i_bus_init,
   // jumpers
   input wire logic [5:0] i_vector_jumper,
   input wire logic i_trigger_source_jumper_a,
   input wire logic i_trigger_source_jumper_b,
   input wire logic i_differential_jumper,
   input wire logic i_unipolar_jumper,
   input wire adcctl_pkg::adcctl_notation_t i_adc_notation,
   input wire logic i_dac_a_unipolar,
   input wire logic i_dac_b_unipolar,
   input wire adcctl_pkg::adcctl_notation_t i_dac_a_notation,
   input wire adcctl_pkg::adcctl_notation_t i_dac_b_notation,
   // start sources
   input wire logic i_rtc_pulse,
   input wire logic i_backplane_event_line,
   input wire logic i_connector_trigger_input,
   // converter
   input wire logic [11:0] i_adc_sample,
   output logic [3:0] o_mux_channel,
   output logic [1:0] o_gain_sel,
   output logic o_mux_differential,
   output logic o_sample_strobe,
   output logic [11:0] o_dac_a,
   output logic [11:0] o_dac_b,
   output logic o_dac_a_ok,
   output logic o_dac_b_ok,
   // interrupt
   output logic o_irq,
   output logic [8:0] o_vector
);
   import adcctl_pkg::*;

   logic [1:0] gain_ff;
   logic [3:0] mux_ff;
   logic trig_en_ff, rtc_en_ff, done_ie_ff, err_ie_ff;
   logic done_ff, err_ff;
   logic [15:0] data_ff;
   logic [11:0] dac_a_ff, dac_b_ff;
   logic [1:0] irq_stat_ff, irq_en_ff;
   logic [31:0] rdata_ff;
   logic ready_ff, slverr_ff, irq_ff, strobe_ff;
   logic [8:0] vec_ff;
   adcctl_state_t state_ff, nxt_state;
   logic [15:0] cnt_ff;
   logic [15:0] fmt_code;
   logic [15:0] csr_rd;
   logic [8:0] base_vec;

   // apb access phase
   wire acc = i_psel & i_penable & ~ready_ff;
   wire wr = acc & i_pwrite;
   wire rd = acc & ~i_pwrite;
   wire wr_csr = wr & (i_paddr == ADDR_CSR);
   wire rd_data = rd & (i_paddr == ADDR_DATA);
   wire mapped = (i_paddr == ADDR_CSR) | (i_paddr == ADDR_DATA) |
      (i_paddr == ADDR_DAC_A) | (i_paddr == ADDR_DAC_B) |
      (i_paddr == ADDR_VECTOR) | (i_paddr == ADDR_IRQ_STATUS) |
      (i_paddr == ADDR_IRQ_CLEAR) | (i_paddr == ADDR_IRQ_ENABLE);

   // start requests
   wire ext_sel = i_trigger_source_jumper_a ? i_backplane_event_line
      : (i_trigger_source_jumper_b & i_connector_trigger_input);
   wire prog_start = wr_csr & i_pwdata[CSR_START];
   wire ext_start = trig_en_ff & ext_sel;
   wire rtc_start = rtc_en_ff & i_rtc_pulse;
   wire any_start = prog_start | ext_start | rtc_start;
   wire busy = (state_ff != ADCCTL_IDLE);
   wire bad_start = any_start & (busy | done_ff);
   wire go = any_start & ~bad_start;
   wire conv_end = (state_ff == ADCCTL_CONV) && (cnt_ff == 16'h0000);

   // conversion sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ADCCTL_IDLE: if (go) nxt_state = ADCCTL_SETTLE;
         ADCCTL_SETTLE: if (cnt_ff == 16'h0000) nxt_state = ADCCTL_CONV;
         ADCCTL_CONV: if (cnt_ff == 16'h0000) nxt_state = ADCCTL_IDLE;
         default: nxt_state = ADCCTL_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_ff <= ADCCTL_IDLE;
         cnt_ff <= 16'h0000;
      end else if (i_clk_en) begin
         if (i_bus_init) begin
            state_ff <= ADCCTL_IDLE;
            cnt_ff <= 16'h0000;
         end else begin
            state_ff <= nxt_state;
            if (state_ff == ADCCTL_IDLE && go) begin
               cnt_ff <= 16'(SETTLE_CYCLES - 1);
            end else if (state_ff == ADCCTL_SETTLE && cnt_ff == 16'h0000) begin
               cnt_ff <= 16'(CONV_CYCLES - 1);
            end else if (cnt_ff != 16'h0000) begin
               cnt_ff <= cnt_ff - 16'h0001;
            end
         end
      end
   end

   adcctl_code_fmt u_fmt (
      .i_raw(i_adc_sample),
      .i_notation(i_adc_notation),
      .o_code(fmt_code)
   );

   // control word fields
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gain_ff <= CSR_RST[CSR_GAIN_LO +: 2];
         mux_ff <= CSR_RST[CSR_MUX_LO +: 4];
         trig_en_ff <= CSR_RST[CSR_TRIG_EN];
         rtc_en_ff <= CSR_RST[CSR_RTC_EN];
         done_ie_ff <= CSR_RST[CSR_DONE_IE];
         err_ie_ff <= CSR_RST[CSR_ERR_IE];
      end else if (i_clk_en) begin
         if (i_bus_init) begin
            done_ie_ff <= 1'b0;
            err_ie_ff <= 1'b0;
            trig_en_ff <= 1'b0;
            rtc_en_ff <= 1'b0;
         end else if (wr_csr) begin
            gain_ff <= i_pwdata[CSR_GAIN_LO +: 2];
            mux_ff <= i_pwdata[CSR_MUX_LO +: 4];
            trig_en_ff <= i_pwdata[CSR_TRIG_EN];
            rtc_en_ff <= i_pwdata[CSR_RTC_EN];
            done_ie_ff <= i_pwdata[CSR_DONE_IE];
            err_ie_ff <= i_pwdata[CSR_ERR_IE];
         end
      end
   end

   // done and error flags, set wins over clear
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         data_ff <= 16'h0000;
      end else if (i_clk_en) begin
         if (conv_end) begin
            done_ff <= 1'b1;
            data_ff <= fmt_code;
         end else if (rd_data | i_bus_init) begin
            done_ff <= 1'b0;
         end
         if (bad_start) begin
            err_ff <= 1'b1;
         end else if (wr_csr | i_bus_init) begin
            err_ff <= 1'b0;
         end
      end
   end

   // dacs
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dac_a_ff <= DAC_RST;
         dac_b_ff <= DAC_RST;
      end else if (i_clk_en) begin
         if (wr && i_paddr == ADDR_DAC_A) dac_a_ff <= i_pwdata[11:0];
         if (wr && i_paddr == ADDR_DAC_B) dac_b_ff <= i_pwdata[11:0];
      end
   end

   // sticky interrupt status, enable and clear
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         irq_stat_ff <= 2'b00;
         irq_en_ff <= 2'b00;
      end else if (i_clk_en) begin
         if (wr && i_paddr == ADDR_IRQ_ENABLE) irq_en_ff <= i_pwdata[1:0];
         irq_stat_ff[IRQ_DONE] <= conv_end | (irq_stat_ff[IRQ_DONE] &
            ~(wr && i_paddr == ADDR_IRQ_CLEAR && i_pwdata[IRQ_DONE]));
         irq_stat_ff[IRQ_ERR] <= bad_start | (irq_stat_ff[IRQ_ERR] &
            ~(wr && i_paddr == ADDR_IRQ_CLEAR && i_pwdata[IRQ_ERR]));
      end
   end

   // vector and interrupt line
   assign base_vec = {i_vector_jumper, 3'b000};
   wire done_req = done_ff & done_ie_ff;
   wire err_req = err_ff & err_ie_ff;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         irq_ff <= 1'b0;
         vec_ff <= 9'h000;
      end else if (i_clk_en) begin
         irq_ff <= done_req | err_req | |(irq_stat_ff & irq_en_ff);
         if (err_req) begin
            vec_ff <= base_vec + VEC_ERR_OFFSET;
         end else begin
            vec_ff <= base_vec;
         end
      end
   end

   // read mux
   assign csr_rd = {err_ff, err_ie_ff, 2'b00, mux_ff, done_ff, done_ie_ff,
      rtc_en_ff, trig_en_ff, gain_ff, 2'b00};
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_ff <= 32'h0000_0000;
         ready_ff <= 1'b0;
         slverr_ff <= 1'b0;
      end else if (i_clk_en) begin
         ready_ff <= acc;
         slverr_ff <= acc & ~mapped;
         if (rd) begin
            case (i_paddr)
               ADDR_CSR: rdata_ff <= {16'h0000, csr_rd};
               ADDR_DATA: rdata_ff <= {16'h0000, data_ff};
               ADDR_VECTOR: rdata_ff <= {23'h00_0000, base_vec};
               ADDR_IRQ_STATUS: rdata_ff <= {30'h0000_0000, irq_stat_ff};
               ADDR_IRQ_ENABLE: rdata_ff <= {30'h0000_0000, irq_en_ff};
               default: rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   // analog side outputs
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_mux_channel <= 4'h0;
         o_gain_sel <= 2'b00;
         o_mux_differential <= 1'b0;
         o_dac_a_ok <= 1'b0;
         o_dac_b_ok <= 1'b0;
         strobe_ff <= 1'b0;
      end else if (i_clk_en) begin
         o_mux_channel <= i_differential_jumper ? {1'b0, mux_ff[2:0]} : mux_ff;
         o_gain_sel <= gain_ff;
         o_mux_differential <= i_differential_jumper;
         o_dac_a_ok <= i_dac_a_unipolar ? (i_dac_a_notation == ADCCTL_BIN)
            : (i_dac_a_notation == ADCCTL_OFFS ||
            i_dac_a_notation == ADCCTL_TWOS);
         o_dac_b_ok <= i_dac_b_unipolar ? (i_dac_b_notation == ADCCTL_BIN)
            : (i_dac_b_notation == ADCCTL_OFFS ||
            i_dac_b_notation == ADCCTL_TWOS);
         strobe_ff <= conv_end;
      end
   end

   assign o_prdata = rdata_ff;
   assign o_pready = ready_ff;
   assign o_pslverr = slverr_ff;
   assign o_irq = irq_ff;
   assign o_vector = vec_ff;
   assign o_sample_strobe = strobe_ff;
   assign o_dac_a = dac_a_ff;
   assign o_dac_b = dac_b_ff;
endmodule

/* verif/adcctl_sva.sv */
`timescale 1ns/10ps
module adcctl_sva (
   // watched ports
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [5:0] i_vector_jumper,
   input wire logic i_dac_a_unipolar,
   input wire adcctl_pkg::adcctl_notation_t i_dac_a_notation,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_sample_strobe,
   input wire logic o_dac_a_ok,
   input wire logic [8:0] o_vector
);
   import adcctl_pkg::*;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_b);
   sequence acc_s;
      i_clk_en && i_psel && i_penable && !o_pready;
   endsequence
   ready_wait_a: assert property (acc_s |=> o_pready)
      else $error("no ready after access");
   ready_once_a: assert property (o_pready |=> !o_pready)
      else $error("ready held");
   ready_cause_a: assert property (o_pready |-> $past(i_psel && i_penable))
      else $error("ready without access");
   err_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("slverr without ready");
   strobe_once_a: assert property (o_sample_strobe |=> !o_sample_strobe)
      else $error("strobe held");
   vec_low_a: assert property (o_vector[1:0] == 2'h0)
      else $error("vector low bits set");
   vec_base_a: assert property ($past(i_rst_b) && $past(i_clk_en)
      && $stable(i_vector_jumper) |-> o_vector[8:3] == i_vector_jumper)
      else $error("vector not from jumpers");
   dac_pair_a: assert property ($past(i_rst_b) && $past(i_clk_en)
      && $stable(i_dac_a_notation) && $stable(i_dac_a_unipolar)
      |-> o_dac_a_ok == (i_dac_a_unipolar ? i_dac_a_notation == ADCCTL_BIN
      : (i_dac_a_notation == ADCCTL_OFFS || i_dac_a_notation == ADCCTL_TWOS)))
      else $error("dac pairing flag wrong");
endmodule

/* verif/adcctl_front.sv */
`timescale 1ns/10ps
module adcctl_front (
   // clock
   input wire logic i_core_clk,
   // bench commands
   input wire logic [11:0] i_value,
   input wire logic [2:0] i_fire,
   // converter input and start lines
   output logic [11:0] o_adc_sample,
   output logic o_rtc_pulse,
   output logic o_backplane_event_line,
   output logic o_connector_trigger_input
);
   // start lines idle low, one-cycle pulses on command
   always_ff @(posedge i_core_clk) begin
      o_adc_sample <= i_value;
      o_rtc_pulse <= i_fire[0];
      o_backplane_event_line <= i_fire[1];
      o_connector_trigger_input <= i_fire[2];
   end
endmodule

/* verif/adcctl_top_test.sv */
`timescale 1ns/10ps
module adcctl_top_test;
   import adcctl_pkg::*;
   logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, bus_init = 0, er;
   logic ja = 1, jb = 0, dau = 0, dbu = 1, dj = 0, en = 1, pready, pslverr, rtc, bev;
   logic con, irq, oka, okb, mdiff;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [5:0] vj = 6'h20;
   logic [11:0] val = 12'h000, sample, dac_a, dac_b;
   logic [2:0] fire = 3'h0;
   logic [3:0] mux;
   logic [1:0] gain;
   logic [8:0] vec;
   adcctl_notation_t adn = ADCCTL_OFFS, dan = ADCCTL_OFFS, dbn = ADCCTL_BIN;
   adcctl_notation_t tn [4] = '{ADCCTL_OFFS, ADCCTL_BIN, ADCCTL_TWOS, ADCCTL_TWOS};
   logic [11:0] tv [4] = '{12'hfff, 12'hfff, 12'h000, 12'hfff};
   logic [31:0] te [4] = '{32'h0000_0fff, 32'h0000_0fff, 32'h0000_f800, 32'h0000_07ff};
   int num_errors = 0, compares = 0;
   always #5 clk = ~clk;
   adcctl_top #(.SETTLE_CYCLES(2), .CONV_CYCLES(4)) u_dut (.i_core_clk(clk),
      .i_rst_b(rst_b), .i_clk_en(en), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_bus_init(bus_init), .i_vector_jumper(vj),
      .i_trigger_source_jumper_a(ja), .i_trigger_source_jumper_b(jb),
      .i_differential_jumper(dj), .i_unipolar_jumper(1'b0), .i_adc_notation(adn),
      .i_dac_a_unipolar(dau), .i_dac_b_unipolar(dbu), .i_dac_a_notation(dan),
      .i_dac_b_notation(dbn), .i_rtc_pulse(rtc), .i_backplane_event_line(bev),
      .i_connector_trigger_input(con), .i_adc_sample(sample), .o_mux_channel(mux),
      .o_gain_sel(gain), .o_mux_differential(mdiff), .o_sample_strobe(), .o_dac_a(dac_a),
      .o_dac_b(dac_b), .o_dac_a_ok(oka), .o_dac_b_ok(okb), .o_irq(irq), .o_vector(vec));
   adcctl_front u_front (.i_core_clk(clk), .i_value(val), .i_fire(fire),
      .o_adc_sample(sample), .o_rtc_pulse(rtc), .o_backplane_event_line(bev),
      .o_connector_trigger_input(con));
   task automatic final_report;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic wirq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, irq}, 32'h0000_0001);
   endtask
   task automatic conv(input logic [2:0] f, input logic [31:0] control_status_word, input logic dn);
      xfer(1, ADDR_CSR, control_status_word);
      @(posedge clk);
      fire <= f;
      @(posedge clk);
      fire <= 3'h0;
      repeat (20) @(posedge clk);
      xfer(0, ADDR_CSR, 32'h0000_0000);
      chk(rd & 32'h0000_0080, dn ? 32'h0000_0080 : 32'h0000_0000);
      xfer(0, ADDR_DATA, 32'h0000_0000);
   endtask
   initial begin
      #300us;
      num_errors++;
      final_report;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1;
      rdchk(ADDR_CSR, 32'h0000_0000);
      xfer(1, ADDR_CSR, 32'h0000_cffc);
      rdchk(ADDR_CSR, 32'h0000_4f7c);
      chk({25'h0, mdiff, gain, mux}, 32'h0000_003f);
      bus_init <= 1;
      repeat (2) @(posedge clk);
      bus_init <= 0;
      rdchk(ADDR_CSR, 32'h0000_0f0c);
      for (int i = 0; i < 4; i++) begin
         adn <= tn[i];
         val <= tv[i];
         xfer(1, ADDR_CSR, 32'h0000_0041);
         wirq;
         chk({23'h0, vec}, 32'h0000_0100);
         rdchk(ADDR_DATA, te[i]);
         rdchk(ADDR_CSR, 32'h0000_0040);
      end
      xfer(1, ADDR_CSR, 32'h0000_4001);
      xfer(1, ADDR_CSR, 32'h0000_4001);
      wirq;
      chk({23'h0, vec}, 32'h0000_0104);
      rdchk(ADDR_CSR, 32'h0000_c080);
      xfer(1, ADDR_CSR, 32'h0000_0000);
      rdchk(ADDR_CSR, 32'h0000_0080);
      xfer(0, ADDR_DATA, 32'h0000_0000);
      rdchk(ADDR_IRQ_STATUS, 32'h0000_0003);
      xfer(1, ADDR_IRQ_ENABLE, 32'h0000_0003);
      rdchk(ADDR_IRQ_ENABLE, 32'h0000_0003);
      chk({31'h0, irq}, 32'h0000_0001);
      xfer(1, ADDR_IRQ_CLEAR, 32'h0000_0003);
      rdchk(ADDR_IRQ_STATUS, 32'h0000_0000);
      xfer(1, ADDR_IRQ_ENABLE, 32'h0000_0000);
      rdchk(8'h20, 32'h0000_0000);
      chk({31'h0, er}, 32'h0000_0001);
      conv(3'h1, 32'h0000_0010, 0);
      conv(3'h1, 32'h0000_0020, 1);
      conv(3'h2, 32'h0000_0010, 1);
      ja <= 0;
      jb <= 1;
      conv(3'h2, 32'h0000_0010, 0);
      conv(3'h4, 32'h0000_0010, 1);
      xfer(1, ADDR_DAC_A, 32'h0000_0abc);
      xfer(1, ADDR_DAC_B, 32'h0000_0123);
      chk({8'h0, dac_a, dac_b}, 32'h00ab_c123);
      for (int u = 0; u < 2; u++) begin
         for (int n = 0; n < 3; n++) begin
            dau <= u[0];
            dan <= adcctl_notation_t'(n);
            repeat (3) @(posedge clk);
            chk({31'h0, oka}, (u == 1) == (n == 0) ? 32'h1 : 32'h0);
         end
      end
      chk({31'h0, okb}, 32'h0000_0001);
      xfer(1, ADDR_CSR, 32'h0000_0f00);
      dj <= 1;
      repeat (3) @(posedge clk);
      chk({27'h0, mdiff, mux}, 32'h0000_0017);
      vj <= 6'h3f;
      en <= 0;
      repeat (3) @(posedge clk);
      chk({23'h0, vec}, 32'h0000_0100);
      en <= 1;
      repeat (3) @(posedge clk);
      chk({23'h0, vec}, 32'h0000_01f8);
      final_report;
   end
endmodule
bind adcctl_top adcctl_sva u_sva (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
   .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable),
   .i_vector_jumper(i_vector_jumper), .i_dac_a_unipolar(i_dac_a_unipolar),
   .i_dac_a_notation(i_dac_a_notation), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_sample_strobe(o_sample_strobe), .o_dac_a_ok(o_dac_a_ok), .o_vector(o_vector));
